/* mal_pkg.sv */
/*
  Package for the motion activity link control block: register offsets,
  field positions, reset values, interplay encodings and motion states.
  Assumes a 32-bit classic Wishbone register bus and a word-aligned map.
*/
package mal_pkg;

  // Register byte offsets
  localparam logic [7:0] MAL_OFS_CTRL        = 8'h00;
  localparam logic [7:0] MAL_OFS_ACT_THR     = 8'h04;
  localparam logic [7:0] MAL_OFS_ACT_TIME    = 8'h08;
  localparam logic [7:0] MAL_OFS_INACT_THR   = 8'h0C;
  localparam logic [7:0] MAL_OFS_INACT_TIME  = 8'h10;
  localparam logic [7:0] MAL_OFS_STATUS      = 8'h14;
  localparam logic [7:0] MAL_OFS_MASK        = 8'h18;

  // Control register fields
  localparam int MAL_CTRL_ACT_EN     = 0;
  localparam int MAL_CTRL_INACT_EN   = 1;
  localparam int MAL_CTRL_ACT_REF    = 2;
  localparam int MAL_CTRL_INACT_REF  = 3;
  localparam int MAL_CTRL_MODE_LO    = 4;
  localparam int MAL_CTRL_MODE_HI    = 5;
  localparam int MAL_CTRL_AUTOSLEEP  = 6;
  localparam int MAL_CTRL_AWAKE_P1   = 7;
  localparam int MAL_CTRL_AWAKE_P2   = 8;
  localparam int MAL_CTRL_W          = 9;

  // Status register fields
  localparam int MAL_ST_ACT          = 0;
  localparam int MAL_ST_INACT        = 1;
  localparam int MAL_ST_AWAKE        = 6;
  localparam int MAL_ST_WAKEUP       = 7;

  // Widths
  localparam int MAL_SAMPLE_W        = 12;
  localparam int MAL_MAG_W           = 13;
  localparam int MAL_ACT_TIME_W      = 8;
  localparam int MAL_INACT_TIME_W    = 16;
  localparam int MAL_AXES            = 3;

  // Reset values
  localparam logic [MAL_CTRL_W-1:0]       MAL_CTRL_RST  = 9'h000;
  localparam logic [MAL_SAMPLE_W-1:0]     MAL_THR_RST   = 12'h000;
  localparam logic [MAL_ACT_TIME_W-1:0]   MAL_ATIME_RST = 8'h00;
  localparam logic [MAL_INACT_TIME_W-1:0] MAL_ITIME_RST = 16'h0000;
  localparam logic [1:0]                  MAL_MASK_RST  = 2'h0;

  // Interplay modes
  typedef enum logic [1:0] {
    MAL_MODE_DEFAULT = 2'b00,
    MAL_MODE_LINKED  = 2'b01,
    MAL_MODE_ALT     = 2'b10,
    MAL_MODE_LOOP    = 2'b11
  } mal_mode_t;

  // Motion state, one-hot
  typedef enum logic [1:0] {
    MAL_ASLEEP = 2'b01,
    MAL_AWAKE  = 2'b10
  } mal_motion_t;

endpackage

/* mal_motion_ctrl.sv */
/*
  Motion activity link control: activity and inactivity detection on
  output samples, default/linked/loop interplay, autosleep, awake flag,
  status and mask registers and two interrupt pins.
  Assumes one 50 MHz clock, a synchronous active-high reset, a classic
  Wishbone master and one sample_valid_i pulse per output sample.
*/
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
// Function
// [RL1] Absolute inactivity: set count of consecutive samples below threshold.
// [RL2] Referenced inactivity: samples stay within deviation of the reference.
// [RL3] Inactivity timer counts samples, from one up to 65,535.
// [RL4] Host uses absolute inactivity when building free-fall detection.
// [RL5] After reset both detectors are disabled until software enables them.
// [RL6] Default mode runs both detectors; each event latches until serviced.
// [RL7] Linked mode keeps at most one detector running, alternating.
// [RL8] Linked: after activity the device is moving, watches only inactivity.
// [RL9] Linked: after inactivity the device is stationary, watches activity.
// [RL10] Linked: pending event must be serviced before next detector arms.
// [RL11] Loop mode alternates like linked but clears events itself.
// [RL12] Autosleep in linked/loop: wake-up on inactivity, back on activity.
// [RL13] Default mode ignores autosleep and never changes operating state.
// [RL14] Awake flag sets on activity and clears on inactivity.
// [RL15] Awake flag may be routed onto either interrupt pin.
// [RL16] Inactivity counter restarts on a violating sample or on re-arming.
// [RL17] Activity: above threshold, absolute or referenced, for activity time.
// [RL18] Activity timer only in measurement; wake-up uses one sample.
// [RL19] Reference recaptured on enable, linked restart or unlinked repeat.
`timescale 1ns/1ns
module mal_motion_ctrl
  import mal_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Sample stream
  input  wire logic                    sample_valid_i,
  input  wire logic [MAL_SAMPLE_W-1:0] sample_x_i,
  input  wire logic [MAL_SAMPLE_W-1:0] sample_y_i,
  input  wire logic [MAL_SAMPLE_W-1:0] sample_z_i,
  // Status outputs
  output logic                         wakeup_mode_o,
  output logic                         awake_o,
  output logic                         irq_o,
  output logic                         irq_pin_one_o,
  output logic                         irq_pin_two_o
);

  logic [MAL_CTRL_W-1:0]       ctrl_q;
  logic [MAL_SAMPLE_W-1:0]     act_thr_q;
  logic [MAL_ACT_TIME_W-1:0]   act_time_q;
  logic [MAL_SAMPLE_W-1:0]     inact_thr_q;
  logic [MAL_INACT_TIME_W-1:0] inact_time_q;
  logic                        st_act_q;
  logic                        st_inact_q;
  logic [1:0]                  mask_q;
  logic                        ack_q;
  logic [31:0]                 rdat_q;
  mal_motion_t                 motion_q;
  logic                        wakeup_q;
  logic                        ref_req_q;
  logic                        act_en_prev_q;
  logic [MAL_ACT_TIME_W-1:0]   act_cnt_q;
  logic [MAL_INACT_TIME_W-1:0] inact_cnt_q;
  logic [MAL_SAMPLE_W-1:0]     ref_q [MAL_AXES];

  logic                        bus_req;
  logic                        wr_en;
  logic                        act_en;
  logic                        inact_en;
  mal_mode_t                   mode;
  logic                        mode_default;
  logic                        mode_loop;
  logic                        autosleep_on;
  logic                        is_awake;
  logic                        pending;
  logic                        act_run;
  logic                        inact_run;
  logic                        judge;
  logic [MAL_SAMPLE_W-1:0]     samp [MAL_AXES];
  logic [MAL_AXES-1:0]         act_hit;
  logic [MAL_AXES-1:0]         inact_hit;
  logic                        act_evt;
  logic                        inact_evt;
  logic [MAL_ACT_TIME_W-1:0]   act_len;
  logic [MAL_INACT_TIME_W-1:0] inact_len;
  logic                        st_w1c_act;
  logic                        st_w1c_inact;
  logic                        ref_trigger;

  // Decode
  assign bus_req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_en        = bus_req & wb_we_i;
  assign act_en       = ctrl_q[MAL_CTRL_ACT_EN];
  assign inact_en     = ctrl_q[MAL_CTRL_INACT_EN];
  assign mode         = mal_mode_t'(ctrl_q[MAL_CTRL_MODE_HI:MAL_CTRL_MODE_LO]);
  assign mode_default = (mode == MAL_MODE_DEFAULT);
  assign mode_loop    = (mode == MAL_MODE_LOOP);
  assign autosleep_on = ctrl_q[MAL_CTRL_AUTOSLEEP] & // see [RL13]
                        ~mode_default;
  assign is_awake     = (motion_q == MAL_AWAKE);
  assign pending      = st_act_q | st_inact_q;

  // Which detectors run
  always_comb begin
    if (mode_default) begin
      act_run   = act_en & ~st_act_q;     // see [RL6]
      inact_run = inact_en & ~st_inact_q; // see [RL6]
    end else if (mode_loop) begin
      act_run   = act_en & ~is_awake;     // see [RL11]
      inact_run = inact_en & is_awake;    // see [RL11]
    end else begin
      act_run   = act_en & ~is_awake & ~pending;  // see [RL7] [RL9] [RL10]
      inact_run = inact_en & is_awake & ~pending; // see [RL7] [RL8] [RL10]
    end
  end

  // No judgement on the sample that captures a new reference
  assign judge = sample_valid_i & ~ref_req_q;

  assign samp[0] = sample_x_i;
  assign samp[1] = sample_y_i;
  assign samp[2] = sample_z_i;

  // Per-axis magnitude compare
  for (genvar g = 0; g < MAL_AXES; g++) begin : g_axis
    logic signed [MAL_MAG_W-1:0] a_dev;
    logic signed [MAL_MAG_W-1:0] i_dev;
    logic        [MAL_MAG_W-1:0] a_mag;
    logic        [MAL_MAG_W-1:0] i_mag;
    logic signed [MAL_MAG_W-1:0] s_ext;
    logic signed [MAL_MAG_W-1:0] r_ext;
    assign s_ext = {samp[g][MAL_SAMPLE_W-1], samp[g]};
    assign r_ext = {ref_q[g][MAL_SAMPLE_W-1], ref_q[g]};
    assign a_dev = ctrl_q[MAL_CTRL_ACT_REF] ? s_ext - r_ext // see [RL17]
                                            : s_ext;
    assign i_dev = ctrl_q[MAL_CTRL_INACT_REF] ? s_ext - r_ext // see [RL2]
                                              : s_ext;
    assign a_mag = a_dev[MAL_MAG_W-1] ? MAL_MAG_W'(-a_dev) : MAL_MAG_W'(a_dev);
    assign i_mag = i_dev[MAL_MAG_W-1] ? MAL_MAG_W'(-i_dev) : MAL_MAG_W'(i_dev);
    assign act_hit[g]   = a_mag > {1'b0, act_thr_q};   // see [RL17]
    assign inact_hit[g] = i_mag < {1'b0, inact_thr_q}; // see [RL1] [RL2]
  end

  // Effective timer lengths, a zero setting acts as one sample
  always_comb begin
    if (wakeup_q || act_time_q == '0) begin
      act_len = MAL_ACT_TIME_W'(1); // see [RL18]
    end else begin
      act_len = act_time_q;
    end
    if (inact_time_q == '0) begin
      inact_len = MAL_INACT_TIME_W'(1); // see [RL3]
    end else begin
      inact_len = inact_time_q;
    end
  end

  assign act_evt   = act_run & judge & (|act_hit) &
                     (act_cnt_q + 1'b1 >= act_len);           // see [RL17]
  assign inact_evt = inact_run & judge & (&inact_hit) &
                     (inact_cnt_q + 1'b1 >= inact_len);       // see [RL1]

  // Activity sample counter
  always_ff @(posedge clk_i) begin
    if (rst_i || !act_run) begin
      act_cnt_q <= '0;
    end else if (judge) begin
      if (!(|act_hit) || act_evt) begin
        act_cnt_q <= '0;
      end else begin
        act_cnt_q <= act_cnt_q + 1'b1; // see [RL17]
      end
    end
  end

  // Inactivity sample counter
  always_ff @(posedge clk_i) begin
    if (rst_i || !inact_run) begin
      inact_cnt_q <= '0; // see [RL16]
    end else if (judge) begin
      if (!(&inact_hit) || inact_evt) begin
        inact_cnt_q <= '0; // see [RL16]
      end else begin
        inact_cnt_q <= inact_cnt_q + 1'b1; // see [RL3]
      end
    end
  end

  // Reference capture requests
  assign ref_trigger = (act_en & ~act_en_prev_q & ~wakeup_q) |
                       (~mode_default & (inact_evt | act_evt)) |
                       (mode_default & act_evt);              // see [RL19]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_en_prev_q <= 1'b0;
      ref_req_q     <= 1'b0;
    end else begin
      act_en_prev_q <= act_en;
      if (ref_trigger) begin
        ref_req_q <= 1'b1; // see [RL19]
      end else if (sample_valid_i) begin
        ref_req_q <= 1'b0;
      end
    end
  end

  for (genvar r = 0; r < MAL_AXES; r++) begin : g_ref
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ref_q[r] <= MAL_THR_RST;
      end else if (ref_req_q && sample_valid_i) begin
        ref_q[r] <= samp[r]; // see [RL19]
      end
    end
  end

  // Motion state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motion_q <= MAL_ASLEEP;
    end else if (act_evt) begin
      motion_q <= MAL_AWAKE;  // see [RL14]
    end else if (inact_evt) begin
      motion_q <= MAL_ASLEEP; // see [RL14]
    end
  end

  // Operating state
  always_ff @(posedge clk_i) begin
    if (rst_i || !autosleep_on) begin
      wakeup_q <= 1'b0; // see [RL13]
    end else if (act_evt) begin
      wakeup_q <= 1'b0; // see [RL12]
    end else if (inact_evt) begin
      wakeup_q <= 1'b1; // see [RL12]
    end
  end

  // Status flags, set wins over software clear
  assign st_w1c_act   = wr_en && wb_adr_i == MAL_OFS_STATUS &&
                        wb_sel_i[0] && wb_dat_i[MAL_ST_ACT];
  assign st_w1c_inact = wr_en && wb_adr_i == MAL_OFS_STATUS &&
                        wb_sel_i[0] && wb_dat_i[MAL_ST_INACT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_act_q <= 1'b0;
    end else if (act_evt) begin
      st_act_q <= 1'b1; // see [RL6]
    end else if (st_w1c_act || (mode_loop && inact_evt)) begin
      st_act_q <= 1'b0; // see [RL11]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_inact_q <= 1'b0;
    end else if (inact_evt) begin
      st_inact_q <= 1'b1; // see [RL6]
    end else if (st_w1c_inact || (mode_loop && act_evt)) begin
      st_inact_q <= 1'b0; // see [RL11]
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q       <= MAL_CTRL_RST; // see [RL5]
      act_thr_q    <= MAL_THR_RST;
      act_time_q   <= MAL_ATIME_RST;
      inact_thr_q  <= MAL_THR_RST;
      inact_time_q <= MAL_ITIME_RST;
      mask_q       <= MAL_MASK_RST;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        MAL_OFS_CTRL: begin
          if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) ctrl_q[8] <= wb_dat_i[8];
        end
        MAL_OFS_ACT_THR: begin
          if (wb_sel_i[0]) act_thr_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) act_thr_q[11:8] <= wb_dat_i[11:8];
        end
        MAL_OFS_ACT_TIME: begin
          if (wb_sel_i[0]) act_time_q <= wb_dat_i[7:0];
        end
        MAL_OFS_INACT_THR: begin
          if (wb_sel_i[0]) inact_thr_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) inact_thr_q[11:8] <= wb_dat_i[11:8];
        end
        MAL_OFS_INACT_TIME: begin
          if (wb_sel_i[0]) inact_time_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) inact_time_q[15:8] <= wb_dat_i[15:8];
        end
        MAL_OFS_MASK: begin
          if (wb_sel_i[0]) mask_q <= wb_dat_i[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Bus answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= bus_req;
      rdat_q <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          MAL_OFS_CTRL:       rdat_q <= {23'h0, ctrl_q};
          MAL_OFS_ACT_THR:    rdat_q <= {20'h0, act_thr_q};
          MAL_OFS_ACT_TIME:   rdat_q <= {24'h0, act_time_q};
          MAL_OFS_INACT_THR:  rdat_q <= {20'h0, inact_thr_q};
          MAL_OFS_INACT_TIME: rdat_q <= {16'h0, inact_time_q};
          MAL_OFS_STATUS: begin
            rdat_q[MAL_ST_ACT]    <= st_act_q;
            rdat_q[MAL_ST_INACT]  <= st_inact_q;
            rdat_q[MAL_ST_AWAKE]  <= is_awake;
            rdat_q[MAL_ST_WAKEUP] <= wakeup_q;
          end
          MAL_OFS_MASK:       rdat_q <= {30'h0, mask_q};
          default:            rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o      = ack_q;
  assign wb_dat_o      = rdat_q;
  assign wakeup_mode_o = wakeup_q;
  assign awake_o       = is_awake;
  assign irq_o         = |({st_inact_q, st_act_q} & mask_q);
  assign irq_pin_one_o = ctrl_q[MAL_CTRL_AWAKE_P1] ? is_awake // see [RL15]
                                                   : irq_o;
  assign irq_pin_two_o = ctrl_q[MAL_CTRL_AWAKE_P2] ? is_awake // see [RL15]
                                                   : irq_o;

endmodule

/* mal_motion_properties.sv */
/*
  Checker for the motion activity link control block: bus answer timing,
  reset state, event timing of awake, wake-up and interrupt outputs.
  Assumes it is bound to mal_motion_ctrl and sees only its ports.
*/
`timescale 1ns/1ns
module mal_motion_props
  import mal_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [7:0]              wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic                    sample_valid_i,
  input wire logic [MAL_SAMPLE_W-1:0] sample_x_i,
  input wire logic [MAL_SAMPLE_W-1:0] sample_y_i,
  input wire logic [MAL_SAMPLE_W-1:0] sample_z_i,
  input wire logic                    wakeup_mode_o,
  input wire logic                    awake_o,
  input wire logic                    irq_o,
  input wire logic                    irq_pin_one_o,
  input wire logic                    irq_pin_two_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside answer");
  AST_RESET_STATE: assert property (disable iff (1'b0) rst_i |=>
    !awake_o && !wakeup_mode_o && !irq_o && !wb_ack_o)
    else $error("outputs not cleared by reset");
  AST_AWAKE_CAUSE: assert property (
    $changed(awake_o) |-> $past(sample_valid_i))
    else $error("awake changed without a sample");
  AST_WAKE_CAUSE: assert property (
    $changed(wakeup_mode_o) |-> $past(sample_valid_i))
    else $error("wake-up mode changed without a sample");
  AST_SLEEP_PAIR: assert property (
    $rose(wakeup_mode_o) |-> $fell(awake_o))
    else $error("wake-up entered without inactivity");
  AST_IRQ_CAUSE: assert property ($rose(irq_o) |->
    $past(sample_valid_i) || $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("interrupt rose without sample or write");
  AST_PIN_ONE: assert property (
    irq_pin_one_o == awake_o || irq_pin_one_o == irq_o)
    else $error("pin one shows neither source");
  AST_PIN_TWO: assert property (
    irq_pin_two_o == awake_o || irq_pin_two_o == irq_o)
    else $error("pin two shows neither source");

  COV_AWAKE: cover property ($rose(awake_o));
  COV_WAKEUP: cover property ($rose(wakeup_mode_o));
  COV_IRQ: cover property ($rose(irq_o));
endmodule

bind mal_motion_ctrl mal_motion_props chk_u (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .sample_valid_i, .sample_x_i, .sample_y_i, .sample_z_i, .wakeup_mode_o,
  .awake_o, .irq_o, .irq_pin_one_o, .irq_pin_two_o);

/* mal_sample_src.sv */
/*
  Sample source model: one sample pulse per request, magnitude on x.
  Assumes requests from the bench on the rising edge of clk_i.
*/
`timescale 1ns/1ns
module mal_sample_src (
  // Clock, reset and request
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        send_i,
  input  wire logic [11:0] mag_i,
  // Sample stream
  output logic             sample_valid_o,
  output logic [11:0]      x_o,
  output logic [11:0]      y_o,
  output logic [11:0]      z_o
);
  // Idle axes toggle so stale data is never mistaken for a sample
  always_ff @(posedge clk_i) begin
    sample_valid_o <= send_i && !rst_i;
    if (rst_i) begin
      {x_o, y_o, z_o} <= 36'h0;
    end else if (send_i) begin
      {x_o, y_o, z_o} <= {mag_i, 24'h0};
    end else begin
      {x_o, y_o, z_o} <= ~{x_o, y_o, z_o};
    end
  end
endmodule

/* mal_tb.sv */
/*
  Testbench: Wishbone register tasks and sample requests, checking
  reset values, default, linked and loop interplay with autosleep.
  Assumes mal_pkg, mal_motion_ctrl and mal_sample_src are compiled first.
*/
`timescale 1ns/1ns
module tb;
  import mal_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, send_q;
  logic        sample_valid_i, wakeup_mode_o, awake_o, irq_o;
  logic        irq_pin_one_o, irq_pin_two_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_q;
  logic [11:0] mag_q, sample_x_i, sample_y_i, sample_z_i;
  int          errors, checks_done;
  logic [31:0] outs;

  assign outs = {27'h0, awake_o, wakeup_mode_o, irq_o, irq_pin_two_o,
                 irq_pin_one_o};

  mal_motion_ctrl dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sample_valid_i,
    .sample_x_i, .sample_y_i, .sample_z_i, .wakeup_mode_o, .awake_o, .irq_o,
    .irq_pin_one_o, .irq_pin_two_o);
  mal_sample_src src_u (.clk_i, .rst_i, .send_i(send_q), .mag_i(mag_q),
    .sample_valid_o(sample_valid_i), .x_o(sample_x_i), .y_o(sample_y_i),
    .z_o(sample_z_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask

  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
    wb_adr_i <= a; wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) chk("ack", 32'h0, 32'h1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    wb(1'b0, a, 32'h0);
    chk(name, rd_q, exp);
  endtask

  task smp(input logic [11:0] m, input int n);
    repeat (n) begin
      send_q <= 1'b1; mag_q <= m;
      @(posedge clk_i);
      send_q <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask

  task do_reset;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Thresholds 100/50, activity 2 samples, inactivity 3 samples
  task setup(input logic [31:0] ctrl);
    wb(1'b1, MAL_OFS_ACT_THR, 32'h64); wb(1'b1, MAL_OFS_ACT_TIME, 32'h2);
    wb(1'b1, MAL_OFS_INACT_THR, 32'h32); wb(1'b1, MAL_OFS_INACT_TIME, 32'h3);
    wb(1'b1, MAL_OFS_MASK, 32'h3); wb(1'b1, MAL_OFS_CTRL, ctrl);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    $display("unexpected run time exp done got timeout");
    stop_test;
  end

  initial begin
    wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 8'h00; wb_sel_i = 4'hF; wb_dat_i = 32'h0;
    send_q = 1'b0; mag_q = 12'h000; errors = 0; checks_done = 0;
    do_reset;
    rd(MAL_OFS_CTRL, 32'h0, "ctrl reset");
    rd(MAL_OFS_STATUS, 32'h0, "status reset");
    rd(MAL_OFS_MASK, 32'h0, "mask reset");
    rd(8'h40, 32'h0, "unmapped");
    $display("test reset done");
    setup(32'h43);
    smp(12'h000, 1); smp(12'h0C8, 1); smp(12'h000, 1);
    rd(MAL_OFS_STATUS, 32'h0, "one high sample");
    smp(12'h0C8, 2);
    rd(MAL_OFS_STATUS, 32'h41, "activity");
    chk("irq", outs, 32'h17);
    wb(1'b1, MAL_OFS_CTRL, 32'h1C3); wb(1'b1, MAL_OFS_MASK, 32'h0);
    chk("pins", outs, 32'h13);
    wb(1'b1, MAL_OFS_CTRL, 32'h43); wb(1'b1, MAL_OFS_MASK, 32'h3);
    smp(12'h0C8, 1); smp(12'h000, 2);
    rd(MAL_OFS_STATUS, 32'h41, "two quiet");
    smp(12'h000, 1);
    rd(MAL_OFS_STATUS, 32'h03, "inactivity");
    chk("default outs", outs, 32'h07);
    wb(1'b1, MAL_OFS_STATUS, 32'h1);
    rd(MAL_OFS_STATUS, 32'h02, "clear one");
    wb(1'b1, MAL_OFS_MASK, 32'h1);
    chk("masked irq", outs, 32'h0);
    wb(1'b1, MAL_OFS_STATUS, 32'h2);
    smp(12'h0C8, 2);
    rd(MAL_OFS_STATUS, 32'h41, "raised again");
    $display("test default done");
    do_reset;
    setup(32'h53);
    smp(12'h000, 1); smp(12'h0C8, 2);
    rd(MAL_OFS_STATUS, 32'h41, "linked activity");
    smp(12'h000, 3);
    rd(MAL_OFS_STATUS, 32'h41, "pending blocks");
    wb(1'b1, MAL_OFS_STATUS, 32'h1);
    smp(12'h000, 2); smp(12'h0C8, 1); smp(12'h000, 2);
    rd(MAL_OFS_STATUS, 32'h40, "moving");
    smp(12'h000, 1);
    rd(MAL_OFS_STATUS, 32'h82, "linked sleep");
    chk("linked outs", outs, 32'h0F);
    smp(12'h0C8, 1);
    rd(MAL_OFS_STATUS, 32'h82, "pending sleep");
    wb(1'b1, MAL_OFS_STATUS, 32'h2);
    smp(12'h000, 1); smp(12'h0C8, 1);
    rd(MAL_OFS_STATUS, 32'h41, "wake one sample");
    $display("test linked done");
    do_reset;
    setup(32'h73);
    smp(12'h000, 1); smp(12'h0C8, 2);
    rd(MAL_OFS_STATUS, 32'h41, "loop activity");
    smp(12'h0C8, 1); smp(12'h000, 3);
    rd(MAL_OFS_STATUS, 32'h82, "loop sleep");
    smp(12'h000, 1); smp(12'h0C8, 1);
    rd(MAL_OFS_STATUS, 32'h41, "loop wake");
    chk("loop outs", outs, 32'h17);
    $display("test loop done");
    do_reset;
    setup(32'h0F);
    smp(12'h3E8, 3);
    rd(MAL_OFS_STATUS, 32'h0, "ref steady");
    smp(12'h3E8, 1);
    rd(MAL_OFS_STATUS, 32'h02, "ref inactivity");
    smp(12'h4B0, 2);
    rd(MAL_OFS_STATUS, 32'h43, "ref activity");
    $display("test referenced done");
    stop_test;
  end
endmodule
